/* File: rtl/ssp_dev.sv */
// device end: strap decode, three-wire spi slave, shadow and active registers
module ssp_dev (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // protocol straps, three-level
    input wire logic [1:0] protocol_strap_low,
    input wire logic [1:0] protocol_strap_high,
    // link
    ssp_link_if.dev link,
    // user side
    output logic spi_mode,
    output logic preset_load,
    output logic [6:0] i2c_addr,
    output logic [ssp_pkg::NREGS-1:0][7:0] active_regs,
    output logic update_pulse
);
    typedef struct packed {
        logic [2:0] strap_wait;
        logic strap_done;
        logic [3:0] strap_code;
        logic sclk_prev;
        ssp_pkg::ssp_phase_type phase;
        logic [3:0] cnt;
        logic [15:0] sh;
        logic [14:0] addr;
        logic [7:0] tx;
        logic d_o;
        logic d_oe;
        logic [7:0] cfg;
        logic [ssp_pkg::NREGS-1:0][7:0] shadow;
        logic [ssp_pkg::NREGS-1:0][7:0] active;
        logic upd;
    } ssp_dev_state_type;

    ssp_dev_state_type r_reg, r_next;
    logic [6:0] sync_q;
    logic sclk_s, cs_s, sdio_s;
    logic [1:0] low_s, high_s;
    logic rise, fall, spi_on, lsb, asc;
    logic [7:0] byte_in;
    logic [15:0] sh_in;

    ssp_sync #(.W(7)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({link.sclk, link.cs_n, link.sdio, protocol_strap_low, protocol_strap_high}),
        .q(sync_q)
    );
    assign {sclk_s, cs_s, sdio_s, low_s, high_s} = sync_q;

    function automatic logic [3:0] lvl_rank(input logic [1:0] lvl);
        lvl_rank = (lvl == ssp_pkg::LVL_FLOAT) ? 4'h0 : ((lvl == ssp_pkg::LVL_LOW) ? 4'h1 : 4'h2);
    endfunction

    function automatic logic [14:0] step(input logic [14:0] a, input logic up);
        if (up) begin
            step = (a == ssp_pkg::ADDR_MAX) ? a : a + 15'h0001; // R18
        end else begin
            step = (a == ssp_pkg::ADDR_MIN) ? a : a - 15'h0001; // R18
        end
    endfunction

    function automatic logic [7:0] rd_byte(input logic [14:0] a);
        if (a == ssp_pkg::REG_CFG) begin
            rd_byte = r_reg.cfg;
        end else if (a == ssp_pkg::REG_UPDATE || a >= ssp_pkg::REG_LIMIT) begin
            rd_byte = ssp_pkg::REG_RESET;
        end else if (r_reg.shadow[ssp_pkg::REG_READBACK[3:0]][ssp_pkg::READBACK_SEL_BIT]) begin
            rd_byte = r_reg.active[a[3:0]]; // R16
        end else begin
            rd_byte = r_reg.shadow[a[3:0]]; // R16
        end
    endfunction

    assign rise = sclk_s & ~r_reg.sclk_prev; // R04
    assign fall = ~sclk_s & r_reg.sclk_prev; // R04
    // protocol is frozen once the straps are caught; nothing but reset reopens it
    assign spi_on = r_reg.strap_done &&
                    (r_reg.strap_code == ssp_pkg::STRAP_PRESET || r_reg.strap_code == ssp_pkg::STRAP_SPI); // R03
    assign lsb = r_reg.cfg[ssp_pkg::CFG_LSB_A] | r_reg.cfg[ssp_pkg::CFG_LSB_B]; // R17
    assign asc = r_reg.cfg[ssp_pkg::CFG_ASC_A] | r_reg.cfg[ssp_pkg::CFG_ASC_B]; // R18
    assign sh_in = lsb ? {sdio_s, r_reg.sh[15:1]} : {r_reg.sh[14:0], sdio_s}; // R11 R17
    assign byte_in = lsb ? {sdio_s, r_reg.sh[7:1]} : {r_reg.sh[6:0], sdio_s}; // R17

    always_comb begin
        r_next = r_reg;
        r_next.upd = 1'b0;
        r_next.sclk_prev = sclk_s;
        if (!r_reg.strap_done) begin
            if (r_reg.strap_wait == ssp_pkg::STRAP_SETTLE) begin
                r_next.strap_done = 1'b1; // R01
                r_next.strap_code = 4'(lvl_rank(low_s) * ssp_pkg::LVL_RADIX) + lvl_rank(high_s); // R02
            end else begin
                r_next.strap_wait = r_reg.strap_wait + 3'h1;
            end
        end
        if (cs_s || !spi_on) begin
            r_next.phase = ssp_pkg::PH_INSTR; // R07 R20
            r_next.cnt = '0; // R20
            r_next.d_oe = 1'b0; // R09
        end else if (rise) begin
            r_next.cnt = r_reg.cnt + 4'h1;
            case (r_reg.phase)
                ssp_pkg::PH_INSTR: begin
                    r_next.sh = sh_in; // R10
                    if (r_reg.cnt == ssp_pkg::INSTR_LAST) begin
                        r_next.cnt = '0;
                        r_next.addr = sh_in[14:0]; // R11
                        if (sh_in[15]) begin
                            r_next.phase = ssp_pkg::PH_READ; // R11
                            r_next.tx = rd_byte(sh_in[14:0]); // R14
                        end else begin
                            r_next.phase = ssp_pkg::PH_WRITE;
                        end
                    end
                end
                ssp_pkg::PH_WRITE: begin
                    r_next.sh[7:0] = byte_in;
                    if (r_reg.cnt == ssp_pkg::BYTE_LAST) begin
                        r_next.cnt = '0;
                        r_next.addr = step(r_reg.addr, asc); // R15
                        if (r_reg.addr == ssp_pkg::REG_CFG) begin
                            // port config acts at once, it is not buffered
                            r_next.cfg = byte_in; // R17
                        end else if (r_reg.addr == ssp_pkg::REG_UPDATE) begin
                            if (byte_in[ssp_pkg::UPDATE_BIT]) begin
                                r_next.active = r_reg.shadow; // R13
                                r_next.upd = 1'b1; // R13
                            end
                        end else if (r_reg.addr < ssp_pkg::REG_LIMIT) begin
                            r_next.shadow[r_reg.addr[3:0]] = byte_in; // R12
                        end
                    end
                end
                default: begin
                    if (r_reg.cnt == ssp_pkg::BYTE_LAST) begin
                        r_next.cnt = '0;
                        r_next.addr = step(r_reg.addr, asc); // R15
                        r_next.tx = rd_byte(step(r_reg.addr, asc)); // R14 R15
                    end
                end
            endcase
        end else if (fall && r_reg.phase == ssp_pkg::PH_READ) begin
            r_next.d_o = lsb ? r_reg.tx[r_reg.cnt[2:0]] : r_reg.tx[~r_reg.cnt[2:0]]; // R04 R14 R17
            r_next.d_oe = 1'b1; // R06
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.dev_sdio_o = r_reg.d_o;
    assign link.dev_sdio_oe = r_reg.d_oe & ~cs_s; // R09
    assign spi_mode = spi_on;
    assign preset_load = r_reg.strap_done && r_reg.strap_code == ssp_pkg::STRAP_PRESET; // R02
    assign i2c_addr = (r_reg.strap_done && !spi_on) ?
                      ssp_pkg::I2C_ADDR_BASE + {3'h0, r_reg.strap_code} : 7'h00; // R02
    assign active_regs = r_reg.active;
    assign update_pulse = r_reg.upd;
endmodule

/* File: rtl/ssp_host.sv */
// host end: command registers driving a three-wire spi master
module ssp_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command port
    input wire logic [4:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // link
    ssp_link_if.host link
);
    typedef struct packed {
        ssp_pkg::ssp_host_state_type st;
        logic [3:0] div;
        logic [5:0] idx;
        logic rw;
        logic [1:0] len;
        logic lsb;
        logic [14:0] start;
        logic [31:0] tx;
        logic [31:0] rx;
        logic [31:0] rdata;
        logic sclk;
        logic cs_n;
        logic d_o;
        logic d_oe;
    } ssp_host_state_type_r_type;

    ssp_host_state_type_r_type r_reg, r_next;
    logic sdio_s, busy, last_bit, half_done;
    logic [5:0] j;
    logic [4:0] pos;
    logic [5:0] nxt;

    ssp_sync #(.W(1)) u_sync (
        .clk(clk),
        .rst(rst),
        .d(link.sdio),
        .q(sdio_s)
    );

    function automatic logic bit_out(input logic [5:0] i);
        logic [5:0] k;
        logic [15:0] iw;
        k = i - ssp_pkg::INSTR_BITS;
        iw = {r_reg.rw, r_reg.start};
        if (i < ssp_pkg::INSTR_BITS) begin
            bit_out = iw[r_reg.lsb ? i[3:0] : ~i[3:0]]; // R11 R17
        end else begin
            bit_out = r_reg.tx[{k[4:3], r_reg.lsb ? k[2:0] : ~k[2:0]}]; // R17
        end
    endfunction

    assign busy = r_reg.st != ssp_pkg::H_IDLE;
    assign half_done = r_reg.div == ssp_pkg::HALF_LAST; // R05
    assign last_bit = r_reg.idx == ssp_pkg::INSTR_BITS + {1'b0, r_reg.len, 3'h7};
    assign j = r_reg.idx - ssp_pkg::INSTR_BITS;
    assign pos = {j[4:3], r_reg.lsb ? j[2:0] : ~j[2:0]};
    assign nxt = r_reg.idx + 6'h01;

    always_comb begin
        r_next = r_reg;
        r_next.div = half_done ? 4'h0 : r_reg.div + 4'h1;
        if (rd) begin
            if (addr == ssp_pkg::HOST_CTRL) begin
                r_next.rdata = {27'h0, r_reg.lsb, r_reg.len, r_reg.rw, 1'b0};
            end else if (addr == ssp_pkg::HOST_ADDR) begin
                r_next.rdata = {17'h0, r_reg.start};
            end else if (addr == ssp_pkg::HOST_TX) begin
                r_next.rdata = r_reg.tx;
            end else if (addr == ssp_pkg::HOST_RX) begin
                r_next.rdata = r_reg.rx;
            end else if (addr == ssp_pkg::HOST_STATUS) begin
                r_next.rdata = {31'h0, busy};
            end else begin
                r_next.rdata = '0;
            end
        end
        case (r_reg.st)
            ssp_pkg::H_IDLE: begin
                if (wr && addr == ssp_pkg::HOST_ADDR) begin
                    r_next.start = wdata[14:0];
                end else if (wr && addr == ssp_pkg::HOST_TX) begin
                    // software writes defaults into reserved and unmapped slots it crosses
                    r_next.tx = wdata; // R19
                end else if (wr && addr == ssp_pkg::HOST_CTRL) begin
                    r_next.rw = wdata[ssp_pkg::CTRL_READ];
                    r_next.len = wdata[ssp_pkg::CTRL_LEN +: 2];
                    r_next.lsb = wdata[ssp_pkg::CTRL_LSB];
                    if (wdata[ssp_pkg::CTRL_START]) begin
                        r_next.st = ssp_pkg::H_LOW;
                        r_next.cs_n = 1'b0; // R07
                        r_next.div = '0;
                        r_next.idx = '0;
                        // bytes of a longer earlier read would otherwise linger in rx
                        r_next.rx = '0;
                    end
                end
            end
            ssp_pkg::H_LOW: begin
                r_next.sclk = 1'b0;
                r_next.d_o = bit_out(r_reg.idx);
                r_next.d_oe = r_reg.idx < ssp_pkg::INSTR_BITS || !r_reg.rw; // R06 R10
                if (half_done) begin
                    r_next.st = ssp_pkg::H_HIGH;
                    r_next.sclk = 1'b1; // R04
                end
            end
            ssp_pkg::H_HIGH: begin
                if (half_done) begin
                    if (r_reg.rw && r_reg.idx >= ssp_pkg::INSTR_BITS) begin
                        r_next.rx[pos] = sdio_s; // R04 R14
                    end
                    r_next.sclk = 1'b0;
                    r_next.idx = nxt;
                    r_next.st = last_bit ? ssp_pkg::H_TAIL : ssp_pkg::H_LOW; // R08
                    r_next.d_oe = 1'b0;
                end
            end
            ssp_pkg::H_TAIL: begin
                if (half_done) begin
                    r_next.cs_n = 1'b1; // R08
                    r_next.st = ssp_pkg::H_GAP;
                end
            end
            default: begin
                if (half_done) begin
                    r_next.st = ssp_pkg::H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.cs_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdata = r_reg.rdata;
    assign link.sclk = r_reg.sclk;
    assign link.cs_n = r_reg.cs_n;
    assign link.host_sdio_o = r_reg.d_o;
    assign link.host_sdio_oe = r_reg.d_oe;
endmodule

/* File: rtl/ssp_link_if.sv */
// three-wire link between host and device
interface ssp_link_if;
    logic sclk;
    logic cs_n;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    logic sdio;
    // shared pin with a weak pull-up when nobody drives
    assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
    modport dev (input sclk, input cs_n, input sdio, output dev_sdio_o, output dev_sdio_oe);
    modport host (output sclk, output cs_n, output host_sdio_o, output host_sdio_oe, input sdio);
endinterface

/* File: rtl/ssp_pkg.sv */
// shared constants and types for the serial control port and its host
// How it works
// [R01] straps sampled once after reset fix protocol
// [R02] strap pairs decode to spi or i2c address
// [R03] protocol changes only by reset
// [R04] write bits rise-captured, read bits fall-launched
// [R05] host sclk no faster than 50 mhz
// [R06] single shared bidirectional data pin
// [R07] active-low chip select gates every transfer
// [R08] host streams bytes, then raises chip select
// [R09] data pin released while chip select high
// [R10] 16-bit instruction word precedes payload
// [R11] read flag first, then 15-bit address; lsb mode sends address first, flag last
// [R12] writes land in shadow registers
// [R13] update bit copies shadow to active, self-clears
// [R14] reads shift eight bits per byte
// [R15] address steps through every location
// [R16] readback source chosen by bit 5
// [R17] msb first default, lsb via config bits
// [R18] ascension bits choose increment or decrement
// [R19] host fills reserved and unmapped with defaults
// [R20] chip select high resets bit counter
package ssp_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCLK_MIN_PERIOD_NS = 20;
    localparam int SCLK_MIN_CYC = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // device answers about six clocks after an sclk edge, so each half must outlast that
    localparam int SYNC_LAT_CYC = 6;
    localparam int HALF_CYC_INT = ((SCLK_MIN_CYC + 1) / 2 > SYNC_LAT_CYC + 2) ?
                                  (SCLK_MIN_CYC + 1) / 2 : SYNC_LAT_CYC + 2;
    localparam logic [3:0] HALF_LAST = 4'(HALF_CYC_INT - 1);
    localparam logic [2:0] STRAP_SETTLE = 3'h3;
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;
    localparam logic [1:0] LVL_FLOAT = 2'h2;
    localparam logic [3:0] LVL_RADIX = 4'h3;
    localparam logic [3:0] STRAP_PRESET = 4'h0;
    localparam logic [3:0] STRAP_SPI = 4'h8;
    localparam logic [6:0] I2C_ADDR_BASE = 7'h38;
    localparam logic [3:0] INSTR_LAST = 4'hf;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [5:0] INSTR_BITS = 6'h10;
    localparam logic [14:0] ADDR_MAX = 15'h7fff;
    localparam logic [14:0] ADDR_MIN = 15'h0000;
    localparam int NREGS = 16;
    localparam logic [14:0] REG_CFG = 15'h000;
    localparam logic [14:0] REG_READBACK = 15'h001;
    localparam logic [14:0] REG_UPDATE = 15'h00f;
    localparam logic [14:0] REG_LIMIT = 15'h010;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int CFG_LSB_A = 6;
    localparam int CFG_LSB_B = 1;
    localparam int CFG_ASC_A = 5;
    localparam int CFG_ASC_B = 2;
    localparam int READBACK_SEL_BIT = 5;
    localparam int UPDATE_BIT = 0;
    // host command port
    localparam logic [4:0] HOST_CTRL = 5'h00;
    localparam logic [4:0] HOST_ADDR = 5'h04;
    localparam logic [4:0] HOST_TX = 5'h08;
    localparam logic [4:0] HOST_RX = 5'h0c;
    localparam logic [4:0] HOST_STATUS = 5'h10;
    localparam int CTRL_START = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_LEN = 2;
    localparam int CTRL_LSB = 4;
    typedef enum logic [1:0] {PH_INSTR, PH_WRITE, PH_READ} ssp_phase_type;
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} ssp_host_state_type;
endpackage

/* File: rtl/ssp_sync.sv */
// two-flop synchroniser for inputs from outside the clock domain
module ssp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssp_sync_state_type;
    ssp_sync_state_type r_reg, r_next;
    always_comb begin
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
    assign q = r_reg.s2;
endmodule

/* File: testbench/ssp_link_props.sv */
// concurrent checks on the three-wire link between host and device
module ssp_link_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic host_sdio_o,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_o,
    input wire logic dev_sdio_oe,
    input wire logic sdio
);
    typedef struct packed {logic sclk_d; logic lsb; logic [15:0] iw; logic [7:0] db; logic [5:0] rises;} ssp_mon_type;
    ssp_mon_type mon_reg;
    ssp_mon_type mon_next;
    // rises counted only inside a frame, so the count restarts at every deselect
    always_comb begin
        mon_next = mon_reg;
        mon_next.sclk_d = sclk;
        if (cs_n) begin
            mon_next.rises = 6'h00;
        end else if (sclk && !mon_reg.sclk_d) begin
            mon_next.rises = mon_reg.rises + 6'h01;
            if (mon_reg.rises < 6'h10) begin
                mon_next.iw = {mon_reg.iw[14:0], sdio};
            end else if (mon_reg.rises < 6'h18) begin
                mon_next.db = {mon_reg.db[6:0], sdio};
            end
            // a write of the port config byte sets the bit order of later frames
            if (mon_reg.rises == 6'h17 && mon_reg.iw == 16'h0000) begin
                mon_next.lsb = mon_next.db[6] | mon_next.db[1];
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) mon_reg <= '0;
        else mon_reg <= mon_next;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_release_idle_pin: assert property (cs_n [*4] |-> !dev_sdio_oe)
        else $error("device drives data pin while deselected");
    a_single_driver: assert property (!(host_sdio_oe && dev_sdio_oe))
        else $error("both ends drive the data pin");
    a_clock_gated: assert property (cs_n |-> !sclk)
        else $error("serial clock moves outside a frame");
    a_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("serial clock high phase not eight cycles");
    a_low_half: assert property ($fell(sclk) && !cs_n |-> !sclk [*8])
        else $error("serial clock low phase too short");
    a_host_data_stable: assert property (sclk && host_sdio_oe |-> $stable(host_sdio_o))
        else $error("host data changes while clock high");
    a_dev_launch_low: assert property (dev_sdio_oe && $changed(dev_sdio_o) |-> !sclk)
        else $error("device data changes while clock high");
    a_instr_first: assert property (dev_sdio_oe && !cs_n |-> mon_reg.rises >= 6'h10)
        else $error("device drives before instruction complete");
    a_read_flag: assert property (dev_sdio_oe && !cs_n |-> (mon_reg.lsb ? mon_reg.iw[0] : mon_reg.iw[15]))
        else $error("device drives without read flag");
    a_whole_bytes: assert property ($rose(cs_n) |-> mon_reg.rises[2:0] == 3'h0 && mon_reg.rises >= 6'h18)
        else $error("frame ends on a partial byte");
endmodule

/* File: testbench/ssp_tb_top.sv */
// self-checking bench joining the host and device ends over the link
module ssp_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] strap_lo = 2'h1;
    logic [1:0] strap_hi = 2'h1;
    logic [4:0] h_addr = 5'h00;
    logic [31:0] h_wdata = 32'h0;
    logic h_wr = 1'b0;
    logic h_rd = 1'b0;
    logic [31:0] h_rdata;
    logic spi_mode;
    logic preset_load;
    logic update_pulse;
    logic [6:0] i2c_addr;
    logic [ssp_pkg::NREGS-1:0][7:0] active_regs;
    logic sclk_d = 1'b0;
    logic [15:0] instr_cap = 16'h0;
    logic lsb_mode = 1'b0;
    int nrise = 0;
    int upd_n = 0;
    int cyc = 0;
    int bad_count = 0;
    int checks = 0;

    always #2 clk = ~clk;

    ssp_link_if ssp_link_if_inst ();
    ssp_dev ssp_dev_inst (.clk(clk), .rst(rst), .protocol_strap_low(strap_lo), .protocol_strap_high(strap_hi),
        .link(ssp_link_if_inst.dev), .spi_mode(spi_mode), .preset_load(preset_load), .i2c_addr(i2c_addr),
        .active_regs(active_regs), .update_pulse(update_pulse));
    ssp_host ssp_host_inst (.clk(clk), .rst(rst), .addr(h_addr), .wdata(h_wdata), .wr(h_wr), .rd(h_rd),
        .rdata(h_rdata), .link(ssp_link_if_inst.host));
    ssp_link_props ssp_link_props_inst (.clk(clk), .rst(rst), .sclk(ssp_link_if_inst.sclk),
        .cs_n(ssp_link_if_inst.cs_n), .host_sdio_o(ssp_link_if_inst.host_sdio_o),
        .host_sdio_oe(ssp_link_if_inst.host_sdio_oe), .dev_sdio_o(ssp_link_if_inst.dev_sdio_o),
        .dev_sdio_oe(ssp_link_if_inst.dev_sdio_oe), .sdio(ssp_link_if_inst.sdio));

    // wire monitor keeps the first sixteen bits of each frame in arrival order
    always @(posedge clk) begin
        sclk_d <= ssp_link_if_inst.sclk;
        if (update_pulse === 1'b1) upd_n <= upd_n + 1;
        if (ssp_link_if_inst.cs_n) begin
            nrise <= 0;
        end else if (ssp_link_if_inst.sclk && !sclk_d) begin
            if (nrise < 16) instr_cap <= {instr_cap[14:0], ssp_link_if_inst.sdio};
            nrise <= nrise + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out;
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        h_addr <= a;
        h_wdata <= d;
        h_wr <= 1'b1;
        @(posedge clk);
        h_wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        h_addr <= a;
        h_rd <= 1'b1;
        @(posedge clk);
        h_rd <= 1'b0;
        @(posedge clk);
        d = h_rdata;
    endtask

    task automatic dev_reset(input logic [1:0] hi, input logic [1:0] lo);
        @(posedge clk);
        rst <= 1'b1;
        strap_hi <= hi;
        strap_lo <= lo;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
    endtask

    // one frame: instruction word checked on the wire, read data checked at the host
    task automatic xfer(input logic rd_op, input logic [14:0] a, input logic [1:0] nm1, input logic [31:0] tx,
        input logic [31:0] exp);
        logic [31:0] st;
        logic [15:0] w;
        logic [15:0] r;
        int k;
        w = {rd_op, a};
        r = {<<{w}};
        bus_wr(ssp_pkg::HOST_ADDR, {17'h0, a});
        bus_wr(ssp_pkg::HOST_TX, tx);
        bus_wr(ssp_pkg::HOST_CTRL, {27'h0, lsb_mode, nm1, rd_op, 1'b1});
        st = 32'h1;
        k = 0;
        while (st[0] !== 1'b0 && k < 1000) begin
            bus_rd(ssp_pkg::HOST_STATUS, st);
            k++;
        end
        chk(st, 32'h0);
        chk({16'h0, instr_cap}, {16'h0, lsb_mode ? r : w});
        if (rd_op) begin
            bus_rd(ssp_pkg::HOST_RX, st);
            chk(st, exp);
        end
    endtask

    task automatic test_straps;
        logic [1:0] lv [3] = '{2'h2, 2'h0, 2'h1};
        logic exp_spi;
        logic [6:0] exp_addr;
        for (int i = 0; i < 9; i++) begin
            dev_reset(lv[i % 3], lv[i / 3]);
            exp_spi = (i == 0 || i == 8);
            exp_addr = exp_spi ? 7'h00 : 7'h38 + 7'(i);
            chk(32'({spi_mode, preset_load, i2c_addr}), 32'({exp_spi, i == 0, exp_addr}));
        end
        strap_hi <= 2'h0;
        strap_lo <= 2'h0;
        repeat (20) @(posedge clk);
        chk(32'({spi_mode, i2c_addr}), 32'({1'b1, 7'h00}));
    endtask

    task automatic test_write_read;
        logic [31:0] v;
        xfer(1'b0, 15'h0003, 2'h1, 32'h5aa5, 32'h0);
        chk(32'(active_regs[3]), 32'h0);
        xfer(1'b1, 15'h0003, 2'h1, 32'h0, 32'h5aa5);
        bus_rd(ssp_pkg::HOST_ADDR, v);
        chk(v, 32'h3);
        bus_rd(ssp_pkg::HOST_CTRL, v);
        chk(v, 32'h6);
    endtask

    task automatic test_update;
        int u0;
        u0 = upd_n;
        xfer(1'b0, 15'h000f, 2'h0, 32'h1, 32'h0);
        chk(32'(upd_n - u0), 32'h1);
        chk(32'({active_regs[3], active_regs[2]}), 32'ha55a);
        xfer(1'b1, 15'h000f, 2'h0, 32'h0, 32'h0);
    endtask

    task automatic test_readback_src;
        xfer(1'b0, 15'h0001, 2'h0, 32'h20, 32'h0);
        xfer(1'b0, 15'h0003, 2'h0, 32'h11, 32'h0);
        xfer(1'b1, 15'h0003, 2'h0, 32'h0, 32'ha5);
        xfer(1'b0, 15'h0001, 2'h0, 32'h00, 32'h0);
        xfer(1'b1, 15'h0003, 2'h0, 32'h0, 32'h11);
    endtask

    // lsb first and ascending set together; byte at 7 was never written
    task automatic test_lsb_ascend;
        xfer(1'b0, 15'h0000, 2'h0, 32'h66, 32'h0);
        lsb_mode = 1'b1;
        xfer(1'b0, 15'h0004, 2'h2, 32'h030201, 32'h0);
        xfer(1'b1, 15'h0004, 2'h3, 32'h0, 32'h030201);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
        test_straps();
        test_write_read();
        test_update();
        test_readback_src();
        test_lsb_ascend();
        close_out();
    end
endmodule
